// ---- flash_margin_protect.v ----
// Command logic for field margin level and protection override, with an AXI4-Lite register slave.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`include "flash_cmd_defines.vh"
module flash_margin_protect #(
	parameter [23:0] PFLASH_BASE = 24'h008000,
	parameter [23:0] PFLASH_LAST = 24'h00ffff,
	parameter [23:0] EEPROM_BASE = 24'h100000,
	parameter [23:0] EEPROM_LAST = 24'h10007f
) (
	// Clock and reset
	input  wire        i_sys_clk,
	input  wire        i_rst,
	// Chip state
	input  wire        i_cmd_allowed,
	input  wire [15:0] i_override_key,
	// AXI4-Lite write
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Margin selection
	output reg  [2:0]  o_pflash_margin,
	output reg  [2:0]  o_eeprom_margin,
	// Protection settings
	output reg  [7:0]  o_pflash_prot,
	output reg  [7:0]  o_eeprom_prot,
	output reg         o_override_active
);
	localparam ST_IDLE = 2'd0;
	localparam ST_EXEC = 2'd1;
	localparam ST_DONE = 2'd2;

	reg  [1:0]  state_r;
	reg  [3:0]  wait_r;
	reg         complete_r;
	reg         access_error_flag_r;
	reg  [2:0]  index_r;
	reg  [15:0] param_r [0:3];
	reg  [7:0]  saved_pflash_r;
	reg  [7:0]  saved_eeprom_r;
	reg         aw_held_r;
	reg  [4:0]  aw_addr_r;
	reg         w_held_r;
	reg  [31:0] w_data_r;

	wire        wr_go    = aw_held_r && w_held_r && !s_axi_bvalid;
	wire [7:0]  cmd_code = param_r[0][15:8];
	wire [23:0] gaddr    = {param_r[0][7:0], param_r[1]};
	wire [15:0] third_param_word = param_r[2];
	wire [15:0] key      = param_r[1];
	wire [1:0]  sel      = param_r[0][1:0];
	wire        in_pf    = gaddr >= PFLASH_BASE && gaddr <= PFLASH_LAST;
	wire        in_ee    = gaddr >= EEPROM_BASE && gaddr <= EEPROM_LAST;
	wire        lvl_ok   = third_param_word <= `LVL_FIELD_M0;
	wire        key_ok   = key == i_override_key && key != `KEY_ERASED;
	wire        launch   = wr_go && aw_addr_r == `OFS_STATUS && w_data_r[`BIT_COMPLETE] && complete_r;

	// Write address/data capture, either order.
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 5'h00;
			w_data_r <= 32'h00000000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r[1:0] != 2'b00) ? 2'b10 : 2'b00;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel.
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
				`OFS_STATUS: begin
					s_axi_rdata <= {24'h000000, complete_r, 1'b0, access_error_flag_r, 5'h00};
				end
				`OFS_INDEX: begin
					s_axi_rdata <= {29'h00000000, index_r};
				end
				`OFS_PARAM0: begin
					s_axi_rdata <= {16'h0000, param_r[0]};
				end
				`OFS_PARAM1: begin
					s_axi_rdata <= {16'h0000, param_r[1]};
				end
				`OFS_PARAM2: begin
					s_axi_rdata <= {16'h0000, param_r[2]};
				end
				`OFS_PARAM3: begin
					s_axi_rdata <= {16'h0000, param_r[3]};
				end
				`OFS_PFLASH_PROT: begin
					s_axi_rdata <= {16'h0000, 7'h00, o_override_active, o_pflash_prot};
				end
				`OFS_EEPROM_PROT: begin
					s_axi_rdata <= {24'h000000, o_eeprom_prot};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Command sequencer and software-visible registers.
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			wait_r <= 4'h0;
			complete_r <= 1'b1;
			access_error_flag_r <= 1'b0;
			index_r <= 3'h0;
			param_r[0] <= 16'h0000;
			param_r[1] <= 16'h0000;
			param_r[2] <= 16'h0000;
			param_r[3] <= 16'h0000;
			o_pflash_prot <= `PROT_RESET;
			o_eeprom_prot <= `PROT_RESET;
			saved_pflash_r <= `PROT_RESET;
			saved_eeprom_r <= `PROT_RESET;
			o_override_active <= 1'b0;
			o_pflash_margin <= 3'h0;
			o_eeprom_margin <= 3'h0;
		end else begin
			if (wr_go && complete_r && s_axi_wstrb[0]) begin
				case (aw_addr_r)
				`OFS_INDEX: index_r <= w_data_r[2:0];
				`OFS_PARAM0: param_r[0] <= w_data_r[15:0];
				`OFS_PARAM1: param_r[1] <= w_data_r[15:0];
				`OFS_PARAM2: param_r[2] <= w_data_r[15:0];
				`OFS_PARAM3: param_r[3] <= w_data_r[15:0];
				`OFS_PFLASH_PROT: o_pflash_prot <= w_data_r[7:0];
				`OFS_EEPROM_PROT: o_eeprom_prot <= w_data_r[7:0];
				`OFS_STATUS: begin
					if (w_data_r[`BIT_ACCESS_ERROR_FLAG]) begin
						access_error_flag_r <= 1'b0;
					end
				end
				default: begin
				end
				endcase
			end
			case (state_r)
			ST_IDLE: begin
				if (launch && !access_error_flag_r) begin
					complete_r <= 1'b0;
					wait_r <= `EXEC_CYCLES;
					state_r <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (wait_r != 4'h0) begin
					wait_r <= wait_r - 4'h1;
				end else begin
					state_r <= ST_DONE;
					if (cmd_code == `CMD_FIELD_MARGIN) begin
						if (index_r != `IDX_TWO || !i_cmd_allowed || !lvl_ok || !(in_pf || in_ee)) begin
							access_error_flag_r <= 1'b1;
						end else if (in_ee) begin
							// EEPROM only, level codes carry bias
							o_eeprom_margin <= third_param_word[2:0];
						end else begin
							// program flash level reaches both arrays
							o_pflash_margin <= third_param_word[2:0];
							o_eeprom_margin <= third_param_word[2:0];
						end
					end else if (cmd_code == `CMD_PROT_OVRD) begin
						// index and mode, errors change nothing
						if ((index_r != `IDX_ONE && index_r != `IDX_TWO && index_r != `IDX_THREE) || !i_cmd_allowed) begin
							access_error_flag_r <= 1'b1;
						end else if (!key_ok) begin
							if (!o_override_active) begin
								access_error_flag_r <= 1'b1;
							end else begin
								o_pflash_prot <= saved_pflash_r;
								o_eeprom_prot <= saved_eeprom_r;
								o_override_active <= 1'b0;
							end
						end else if (sel == 2'b00) begin
							access_error_flag_r <= 1'b1;
						end else begin
							saved_pflash_r <= o_pflash_prot;
							saved_eeprom_r <= o_eeprom_prot;
							if (sel[0]) begin
								o_pflash_prot <= param_r[2][7:0];
							end
							if (sel[1]) begin
								o_eeprom_prot <= param_r[3][7:0];
							end
							o_override_active <= 1'b1;
						end
					end else begin
						access_error_flag_r <= 1'b1;
					end
				end
			end
			ST_DONE: begin
				complete_r <= 1'b1;
				state_r <= ST_IDLE;
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ---- flash_cmd_defines.vh ----
// Constants for the margin level and protection override command block.
// Behaviour
// - EEPROM target: margin on EEPROM reads only
// - Program flash target: margin on both arrays
// - Decode levels zero to four as listed
// - Margin-1 biases erased, margin-0 biases programmed
// - Margin command needs parameter index 010
// - Invalid level or unavailable mode: access error
// - Invalid block address: access error
// - Selection bit 1 updates EEPROM protection
// - Key match saves then overwrites protection
// - Override values accepted without restriction
// - Successful override sets override-active bit
// - Bad or erased key restores, clears active
// - Erased stored key disables override forever
// - Rejected launch leaves protection untouched
// - Single-entry save buffer, overwritten by each successful override
// - Restore discards direct writes, reloads saved values
// - Override index must be 001, 010, 011
// - Restore without prior override: access error
// - Selection 00 with index 010/011: error
// - Selection 00, index 001, valid key: error
// - Clearing complete flag launches; set when done
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH
`define OFS_STATUS      5'h00
`define OFS_INDEX       5'h04
`define OFS_PARAM0      5'h08
`define OFS_PARAM1      5'h0c
`define OFS_PARAM2      5'h10
`define OFS_PARAM3      5'h14
`define OFS_PFLASH_PROT 5'h18
`define OFS_EEPROM_PROT 5'h1c
`define BIT_COMPLETE    7
`define BIT_ACCESS_ERROR_FLAG      5
`define BIT_OVERRIDE    0
`define CMD_FIELD_MARGIN 8'h0e
`define CMD_PROT_OVRD    8'h13
`define LVL_NORMAL      16'h0000
`define LVL_USER_M1     16'h0001
`define LVL_USER_M0     16'h0002
`define LVL_FIELD_M1    16'h0003
`define LVL_FIELD_M0    16'h0004
`define KEY_ERASED      16'hffff
`define IDX_ONE         3'h1
`define IDX_TWO         3'h2
`define IDX_THREE       3'h3
`define PROT_RESET      8'hff
`define EXEC_CYCLES     4'h4
`endif

// ---- flash_margin_protect_chk.sv ----
// Port checker for the margin and protection override command block.
module flash_margin_protect_chk (
	// Clock and reset
	input logic        i_sys_clk,
	input logic        i_rst,
	// Chip state
	input logic        i_cmd_allowed,
	input logic [15:0] i_override_key,
	// Bus handshakes and read data
	input logic        s_axi_awready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	// Results
	input logic [2:0]  o_pflash_margin,
	input logic [2:0]  o_eeprom_margin,
	input logic        o_override_active
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	AST_LEVEL_RANGE: assert property (o_pflash_margin <= 3'h4 && o_eeprom_margin <= 3'h4)
		else $error("margin code out of range");
	AST_PF_BOTH: assert property ($changed(o_pflash_margin) |-> o_eeprom_margin == o_pflash_margin)
		else $error("program flash margin not applied to both");
	AST_NO_MODE: assert property (!i_cmd_allowed [*8] |=> $stable(o_eeprom_margin) && $stable(o_override_active))
		else $error("command ran while unavailable");
	AST_KEY_OFF: assert property ($rose(o_override_active) |-> i_override_key != 16'hffff)
		else $error("override with erased key");
	AST_RD_HOLD: assert property (s_rd_taken ##1 s_rd_wait |=> $stable(s_axi_rdata))
		else $error("read data moved");
	AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready not a pulse");
endmodule
bind flash_margin_protect flash_margin_protect_chk u_chk (.i_sys_clk, .i_rst, .i_cmd_allowed, .i_override_key,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .o_pflash_margin, .o_eeprom_margin, .o_override_active);

// ---- flash_margin_protect_override_cmds_bench.sv ----
// Self-checking bench for the margin and protection override command block.
module flash_margin_protect_override_cmds_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_sys_clk = 0, i_rst = 1, i_cmd_allowed = 1, act = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [15:0] i_override_key = 0, key;
	logic [31:0] s_axi_wdata = 0, v;
	logic [7:0]  pf = 8'hff, ee = 8'hff, a, b;
	logic [1:0]  r;
	logic [63:0] x, notes[$];
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_override_active;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [2:0]  o_pflash_margin, o_eeprom_margin;
	wire  [7:0]  o_pflash_prot, o_eeprom_prot;
	wire  [31:0] s_axi_rdata;
	int          err_total = 0, checks_done = 0;
	flash_margin_protect u_dut (.i_sys_clk, .i_rst, .i_cmd_allowed, .i_override_key, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_pflash_margin, .o_eeprom_margin,
		.o_pflash_prot, .o_eeprom_prot, .o_override_active);
	always #5 i_sys_clk = ~i_sys_clk;
	task stop_test;
		$display("Checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task hang(input int n);
		if (n >= 60) begin
			err_total++;
			stop_test;
		end
	endtask
	task wr(input [4:0] ad, input [31:0] d);
		int n;
		@(posedge i_sys_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 60; n++) begin
			@(posedge i_sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 0;
		hang(n);
	endtask
	task rd(input [4:0] ad, input [31:0] m, input [31:0] e);
		int n;
		notes.push_back({m, e});
		@(posedge i_sys_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 60; n++) begin
			@(posedge i_sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		hang(n);
	endtask
	always @(posedge i_sys_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			x = notes.pop_front();
			if (x[63:32] != 0) chk("rdata", s_axi_rdata & x[63:32], x[31:0]);
		end
	end
	// Parameter words are packed last to first: p3, p2, p1, p0.
	task cmd(input [2:0] ix, input [63:0] p, input bit e);
		int n;
		wr(5'h04, {29'h0, ix});
		for (n = 0; n < 4; n++) wr(5'h08 + 5'(4 * n), {16'h0, p[16*n +: 16]});
		wr(5'h00, 32'h80);
		for (n = 0; n < 60; n++) begin
			rd(5'h00, 0, 0);
			if (v[7]) break;
		end
		hang(n);
		rd(5'h00, 32'ha0, e ? 32'ha0 : 32'h80);
		if (e) wr(5'h00, 32'h20);
		rd(5'h18, 32'h1ff, {23'h0, act, pf});
		rd(5'h1c, 32'hff, {24'h0, ee});
		chk("pf prot", o_pflash_prot, pf);
		chk("ee prot", o_eeprom_prot, ee);
		$display("Command %h done at %0t", p[15:8], $time);
	endtask
	initial begin
		void'($urandom(32'h86fc));
		key = 16'($urandom % 32'hffff);
		a = 8'($urandom);
		b = 8'($urandom);
		i_override_key = key;
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 0;
		rd(5'h18, 32'h1ff, 32'hff);
		wr(5'h02, 0);
		chk("bresp", r, 2);
		rd(5'h1e, 0, 0);
		chk("rresp", r, 2);
		for (int l = 0; l < 5; l++) begin
			cmd(3'h2, {16'h0, 16'(l), 16'h0, 16'h0e10}, 0);
			chk("ee margin", o_eeprom_margin, l);
		end
		cmd(3'h2, {16'h0, 16'h3, 16'h8000, 16'h0e00}, 0);
		cmd(3'h2, {16'h0, 16'h1, 16'h0, 16'h0e10}, 0);
		cmd(3'h3, {16'h0, 16'h2, 16'h0, 16'h0e10}, 1);
		cmd(3'h2, {16'h0, 16'h5, 16'h0, 16'h0e10}, 1);
		cmd(3'h2, {16'h0, 16'h2, 16'h0, 16'h0e00}, 1);
		i_cmd_allowed <= 0;
		cmd(3'h2, {16'h0, 16'h2, 16'h0, 16'h0e10}, 1);
		i_cmd_allowed <= 1;
		chk("pf margin", o_pflash_margin, 3);
		chk("ee margin", o_eeprom_margin, 1);
		cmd(3'h1, {32'h0, ~key, 16'h1300}, 1);
		{pf, ee, act} = {a, b, 1'b1};
		cmd(3'h3, {8'h0, b, 8'h0, a, key, 16'h1303}, 0);
		wr(5'h18, 32'h5a);
		wr(5'h1c, 32'ha5);
		{pf, ee, act} = {8'hff, 8'hff, 1'b0};
		cmd(3'h1, {32'h0, 16'hffff, 16'h1300}, 0);
		{ee, act} = {a, 1'b1};
		cmd(3'h3, {8'h0, a, 8'h0, b, key, 16'h1302}, 0);
		pf = b;
		cmd(3'h2, {16'h0, 8'h0, b, key, 16'h1301}, 0);
		{pf, act} = {8'hff, 1'b0};
		cmd(3'h1, {32'h0, ~key, 16'h1300}, 0);
		cmd(3'h2, {16'h0, 8'h0, b, key, 16'h1300}, 1);
		cmd(3'h1, {32'h0, key, 16'h1300}, 1);
		cmd(3'h4, {8'h0, b, 8'h0, b, key, 16'h1303}, 1);
		i_cmd_allowed <= 0;
		cmd(3'h3, {8'h0, b, 8'h0, b, key, 16'h1303}, 1);
		i_cmd_allowed <= 1;
		i_override_key <= 16'hffff;
		cmd(3'h3, {8'h0, b, 8'h0, b, 16'hffff, 16'h1303}, 1);
		stop_test;
	end
endmodule
